// file: rtl/gre_decoder.sv
/*
 * gre_decoder: gray-coded relative rotary encoder from coil states.
 * assumes: channel levels are 1 while the target covers the coil;
 * the channel select is held static while counting matters.
 */
// Contract
// - a coil reads one when covered by target, zero when clear.
// - two coils give four gray positions ninety degrees apart.
// - plain map (A,B): pos1 10, pos2 11, pos3 01, pos4 00.
// - rotation comes from successive state changes, no absolute reference.
// - positions per revolution equal four times the target count.
// - same sequence for any equivalent coil placement, period four.
// - reference coil is complement of its partner; decide on the difference.
// - reference map (A,Ar,B,Br): 0101, 1001, 1010, 0110.
// - up to six sensing channels feed the encoder coil selection.
module gre_decoder
    import gre_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // sensing channels and selection
    input wire logic [GRE_NUM_CHANNELS-1:0] chan_in,
    input wire gre_cfg_s cfg_in,
    // results
    output gre_status_s status_out,
    output gre_event_s event_out
);
    import gre_pkg::*;

    // ************************************************************
    // channel capture
    // ************************************************************
    logic [GRE_NUM_CHANNELS-1:0] lvl;

    gre_sync u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .raw_in(chan_in),
        .level_out(lvl)
    );

    // ************************************************************
    // coil selection and decision
    // ************************************************************
    // out-of-range channel selects read as clear coils
    wire coil_a = (cfg_in.a < GRE_CHAN_IDX_W'(GRE_NUM_CHANNELS))
        ? lvl[cfg_in.a] : 1'b0;
    wire coil_b = (cfg_in.b < GRE_CHAN_IDX_W'(GRE_NUM_CHANNELS))
        ? lvl[cfg_in.b] : 1'b0;
    wire coil_ar = (cfg_in.a_ref < GRE_CHAN_IDX_W'(GRE_NUM_CHANNELS))
        ? lvl[cfg_in.a_ref] : 1'b0;
    wire coil_br = (cfg_in.b_ref < GRE_CHAN_IDX_W'(GRE_NUM_CHANNELS))
        ? lvl[cfg_in.b_ref] : 1'b0;
    wire [3:0] ref_word = {coil_a, coil_ar, coil_b, coil_br};
    // pair must disagree; equal pair means neither covered nor clear
    wire ref_ok = (coil_a != coil_ar) && (coil_b != coil_br);
    // difference sign of each pair carries the decision
    wire [1:0] ref_ab = {coil_a & ~coil_ar, coil_b & ~coil_br};
    // word rebuilt from the pair differences only
    wire [3:0] ref_norm = {ref_ab[1], ~ref_ab[1], ref_ab[0], ~ref_ab[0]};
    wire [1:0] plain_ab = {coil_a, coil_b};
    wire sample_ok = cfg_in.use_ref ? ref_ok : 1'b1;

    // map gray state to phase 0..3 (position 1..4)
    function automatic logic [1:0] plain_phase(input logic [1:0] s);
        logic [1:0] p;
        p = 2'h0;
        case (s)
            GRE_STATE_POS1: p = 2'h0;
            GRE_STATE_POS2: p = 2'h1;
            GRE_STATE_POS3: p = 2'h2;
            GRE_STATE_POS4: p = 2'h3;
            default: p = 2'h0;
        endcase
        return p;
    endfunction

    function automatic logic [1:0] ref_phase(input logic [3:0] w);
        logic [1:0] p;
        p = 2'h0;
        case (w)
            GRE_REF_POS1: p = 2'h0;
            GRE_REF_POS2: p = 2'h1;
            GRE_REF_POS3: p = 2'h2;
            GRE_REF_POS4: p = 2'h3;
            default: p = 2'h0;
        endcase
        return p;
    endfunction

    wire [1:0] cur_phase = cfg_in.use_ref ? ref_phase(ref_norm)
        : plain_phase(plain_ab);

    // ************************************************************
    // step detection
    // ************************************************************
    gre_state_e state_q;
    gre_state_e state_d;
    logic [1:0] phase_q;
    logic [GRE_COUNT_W-1:0] count_q;
    logic [GRE_POS_W-1:0] pos_q;
    logic up_q;
    logic down_q;
    logic inv_q;
    logic valid_q;

    // only relative steps matter, so placement at 4n offsets is harmless
    wire [1:0] delta = cur_phase - phase_q;
    wire tracking = (state_q == GRE_ST_TRACK) && sample_ok;
    wire step_up = tracking && (delta == 2'h1);
    wire step_down = tracking && (delta == 2'h3);
    wire step_bad = tracking && (delta == 2'h2);
    wire [GRE_POS_W-1:0] pos_wrap = GRE_POS_W'(GRE_POS_PER_REV - 1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            GRE_ST_INIT: begin
                if (sample_ok) begin
                    state_d = GRE_ST_TRACK;
                end
            end
            GRE_ST_TRACK: begin
                if (!sample_ok) begin
                    state_d = GRE_ST_FAULT;
                end
            end
            GRE_ST_FAULT: begin
                // relearn the phase without counting the jump
                if (sample_ok) begin
                    state_d = GRE_ST_TRACK;
                end
            end
            default: state_d = GRE_ST_INIT;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_q <= GRE_ST_INIT;
            phase_q <= GRE_PHASE_RST;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            valid_q <= (state_d == GRE_ST_TRACK);
            // a jump relearns the phase so the next step keeps its direction
            if (sample_ok) begin
                phase_q <= cur_phase;
            end
        end
    end

    // ************************************************************
    // counters
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_q <= GRE_COUNT_RST;
            pos_q <= GRE_POS_RST;
        end else if (step_up) begin
            count_q <= count_q + 1'b1;
            pos_q <= (pos_q == pos_wrap) ? GRE_POS_RST : pos_q + 1'b1;
        end else if (step_down) begin
            count_q <= count_q - 1'b1;
            pos_q <= (pos_q == GRE_POS_RST) ? pos_wrap : pos_q - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            inv_q <= 1'b0;
        end else begin
            up_q <= step_up;
            down_q <= step_down;
            inv_q <= step_bad;
        end
    end

    assign status_out.count = count_q;
    assign status_out.position = pos_q;
    assign status_out.phase = phase_q;
    assign status_out.valid = valid_q;
    assign event_out.step_up = up_q;
    assign event_out.step_down = down_q;
    assign event_out.invalid = inv_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence seq_up_step;
        step_up ##1 (up_q && !down_q && $changed(pos_q));
    endsequence

    AST_UP_COUNTS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_up |=> (count_q == $past(count_q) + 16'h0001))
        else $error("count did not rise on up step");
    AST_DOWN_COUNTS: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        step_down |=> (count_q == $past(count_q) - 16'h0001))
        else $error("count did not fall on down step");
    AST_JUMP_HOLDS: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        step_bad |=> ($stable(count_q) && inv_q))
        else $error("two-bit jump changed count");
    AST_UP_EVENT: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        step_up |-> seq_up_step)
        else $error("up event missing");
    AST_POS_RANGE: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        pos_q == count_q[GRE_POS_W-1:0])
        else $error("position lost step with counter");
    AST_POS_WRAP: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (step_up && pos_q == pos_wrap) |=> (pos_q == GRE_POS_RST))
        else $error("position failed to wrap");
    AST_PLAIN_MAP: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (!cfg_in.use_ref && plain_ab == 2'h3) |-> (cur_phase == 2'h1))
        else $error("plain state 11 not position two");
    AST_REF_MAP: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (cfg_in.use_ref && ref_word == 4'hA) |-> (cur_phase == 2'h2))
        else $error("reference state 1010 not position three");
    AST_REF_FAULT: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (cfg_in.use_ref && !ref_ok) |=> !status_out.valid)
        else $error("equal reference pair still tracked");
    AST_NO_EVENT_ON_FAULT: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !sample_ok |=> !(up_q || down_q))
        else $error("step counted on bad sample");

endmodule

// file: rtl/gre_pkg.sv
/*
 * gre_pkg: shared constants and carriers of the rotary encoder decoder.
 * assumes: coil states arrive as already-thresholded digital levels.
 */
package gre_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int GRE_NUM_CHANNELS = 6;
    localparam int GRE_CHAN_IDX_W = 3;
    localparam int GRE_NUM_TARGETS = 8;
    localparam int GRE_STATES_PER_TARGET = 4;
    localparam int GRE_POS_PER_REV = GRE_STATES_PER_TARGET * GRE_NUM_TARGETS;
    localparam int GRE_POS_W = 5;
    localparam int GRE_COUNT_W = 16;

    // ************************************************************
    // gray states, coil a in bit 1, coil b in bit 0
    // ************************************************************
    localparam logic [1:0] GRE_STATE_POS1 = 2'h2;
    localparam logic [1:0] GRE_STATE_POS2 = 2'h3;
    localparam logic [1:0] GRE_STATE_POS3 = 2'h1;
    localparam logic [1:0] GRE_STATE_POS4 = 2'h0;

    // with references: {a, a_ref, b, b_ref}
    localparam logic [3:0] GRE_REF_POS1 = 4'h5;
    localparam logic [3:0] GRE_REF_POS2 = 4'h9;
    localparam logic [3:0] GRE_REF_POS3 = 4'hA;
    localparam logic [3:0] GRE_REF_POS4 = 4'h6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [GRE_COUNT_W-1:0] GRE_COUNT_RST = 16'h0000;
    localparam logic [GRE_POS_W-1:0] GRE_POS_RST = 5'h00;
    localparam logic [1:0] GRE_PHASE_RST = 2'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [GRE_CHAN_IDX_W-1:0] a;
        logic [GRE_CHAN_IDX_W-1:0] a_ref;
        logic [GRE_CHAN_IDX_W-1:0] b;
        logic [GRE_CHAN_IDX_W-1:0] b_ref;
        logic use_ref;
    } gre_cfg_s;

    typedef struct packed {
        logic [GRE_COUNT_W-1:0] count;
        logic [GRE_POS_W-1:0] position;
        logic [1:0] phase;
        logic valid;
    } gre_status_s;

    typedef struct packed {
        logic step_up;
        logic step_down;
        logic invalid;
    } gre_event_s;

    typedef enum logic [1:0] {
        GRE_ST_INIT,
        GRE_ST_TRACK,
        GRE_ST_FAULT
    } gre_state_e;

endpackage

// file: rtl/gre_sync.sv
/*
 * gre_sync: three-flop input synchroniser per sensing channel.
 * assumes: channel levels come from the sensing front end on another clock.
 */
module gre_sync
    import gre_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // channels
    input wire logic [GRE_NUM_CHANNELS-1:0] raw_in,
    output logic [GRE_NUM_CHANNELS-1:0] level_out
);
    import gre_pkg::*;

    // ************************************************************
    // per channel synchroniser and agreement filter
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < GRE_NUM_CHANNELS; i++) begin : g_ch
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            wire agree = (s2_q == s3_q);
            always_ff @(posedge clk_in) begin
                s1_q <= raw_in[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
            end
            // level follows the pin in reset: no false step at release
            always_ff @(posedge clk_in) begin
                // change counts once second and third agree
                if (!reset_n_in || agree) begin
                    lvl_q <= s3_q;
                end
            end
            assign level_out[i] = lvl_q;
        end
    endgenerate

endmodule

// file: tb/gre_dial_model.sv
/*
 * gre_dial_model: coils over a rotating target dial, thresholded levels.
 * assumes: the bench turns the dial by setting its quarter phase.
 */
module gre_dial_model
    import gre_pkg::*;
(
    // dial position and fault injection
    input wire logic [1:0] phase_in,
    input wire logic tie_ref_in,
    // coil levels per sensing channel
    output logic [GRE_NUM_CHANNELS-1:0] chan_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import gre_pkg::*;

    // ************************************************************
    // coil levels
    // ************************************************************
    logic [1:0] plain_ab;
    logic [3:0] ref_set;

    // covered coil reads 1, clear coil reads 0
    assign plain_ab = (phase_in == 2'h0) ? 2'h2 :
                      (phase_in == 2'h1) ? 2'h3 :
                      (phase_in == 2'h2) ? 2'h1 : 2'h0;
    // reference coils sit opposite their partners
    assign ref_set = (phase_in == 2'h0) ? 4'h5 :
                     (phase_in == 2'h1) ? 4'h9 :
                     (phase_in == 2'h2) ? 4'hA : 4'h6;
    // plain pair on channels 0,1; reference set on 2..5
    assign chan_out[0] = plain_ab[1];
    assign chan_out[1] = plain_ab[0];
    assign chan_out[2] = ref_set[3];
    // a broken reference coil copies its partner
    assign chan_out[3] = tie_ref_in ? ref_set[3] : ref_set[2];
    assign chan_out[4] = ref_set[1];
    assign chan_out[5] = ref_set[0];
endmodule

// file: tb/tb_top.sv
/*
 * tb_top: directed bench of the rotary encoder decoder.
 * assumes: a 10-cycle reset also flushes the input synchroniser.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gre_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [1:0] dial_q = 2'h0;
    logic tie_q = 1'b0;
    gre_cfg_s cfg = '0;
    logic [GRE_NUM_CHANNELS-1:0] chan;
    gre_status_s st;
    gre_event_s ev;
    int fails = 0;
    int samples_checked = 0;
    int n_up = 0, n_dn = 0, n_inv = 0;
    int e_up, e_dn, e_inv;
    logic [15:0] e_cnt;
    logic [4:0] e_pos;

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    gre_dial_model gre_dial_model_i (.phase_in(dial_q), .tie_ref_in(tie_q),
        .chan_out(chan));
    gre_decoder gre_decoder_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .chan_in(chan), .cfg_in(cfg), .status_out(st), .event_out(ev));

    // pulses last one cycle, so tally them away from the launching edge
    always @(negedge clk_in) begin
        n_up += (ev.step_up === 1'b1);
        n_dn += (ev.step_down === 1'b1);
        n_inv += (ev.invalid === 1'b1);
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic check_all();
        check(st.count, e_cnt);
        check(st.position, e_pos);
        check(st.phase, dial_q);
        check(st.valid, 1'b1);
        check(n_up, e_up);
        check(n_dn, e_dn);
        check(n_inv, e_inv);
    endtask

    task automatic do_reset(input logic ref_mode);
        @(posedge clk_in);
        #1;
        reset_n_in = 1'b0;
        dial_q = 2'h0;
        cfg.use_ref = ref_mode;
        repeat (10) @(posedge clk_in);
        #1;
        check(st, '0);
        reset_n_in = 1'b1;
        {e_cnt, e_pos} = '0;
        {n_up, n_dn, n_inv} = '0;
        {e_up, e_dn, e_inv} = '0;
        repeat (8) @(posedge clk_in);
        #1;
        check_all();
    endtask

    // moves the dial, spaced by one cycle each, then lets it settle
    task automatic turn(input int dir, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            #1;
            dial_q = dial_q + 2'(dir);
            if (dir == 2) begin
                e_inv++;
            end else begin
                e_cnt = e_cnt + 16'(dir);
                e_pos = e_pos + 5'(dir);
                if (dir > 0) e_up++;
                else e_dn++;
            end
        end
        repeat (8) @(posedge clk_in);
        #1;
        check_all();
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_full_rev();
        // plain pair sits on channels 0 and 1
        cfg.a = 3'h0;
        cfg.b = 3'h1;
        do_reset(1'b0);
        for (int i = 0; i < 32; i++) turn(1, 1);
        check(st.position, 5'h00);
    endtask

    task automatic t_back_to_back();
        turn(-1, 3);
        turn(1, 1);
    endtask

    task automatic t_jump();
        turn(2, 1);
        turn(-1, 1);
    endtask

    task automatic t_ref_walk();
        cfg.a = 3'h2;
        cfg.a_ref = 3'h3;
        cfg.b = 3'h4;
        cfg.b_ref = 3'h5;
        do_reset(1'b1);
        turn(1, 4);
        turn(-1, 2);
    endtask

    task automatic t_ref_fault();
        @(posedge clk_in);
        #1;
        tie_q = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        check(st.valid, 1'b0);
        tie_q = 1'b0;
        repeat (10) @(posedge clk_in);
        #1;
        check_all();
        turn(1, 1);
    endtask

    // ************************************************************
    // run control
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        t_full_rev();
        t_back_to_back();
        t_jump();
        t_ref_walk();
        t_ref_fault();
        tally_and_finish();
    end

    // whole run is about 414 cycles; allow about eighteen times that
    initial begin
        #30000;
        fails++;
        tally_and_finish();
    end
endmodule
